// ---- hw/sbrw_params.svh ----
// Constants of the DDR burst read/write engine
`ifndef SBRW_PARAMS_SVH
`define SBRW_PARAMS_SVH
// ==========================================================
// Widths
`define SBRW_DQ_W 16
`define SBRW_LANES 2
`define SBRW_LAT_W 5
`define SBRW_BANK_W 3
`define SBRW_COL_W 10
`define SBRW_WRAP_W 3
// ==========================================================
// Burst-length field codes and burst sizes in link cycles
`define SBRW_BL_FIXED8 2'h0
`define SBRW_BL_OTF 2'h1
`define SBRW_PAIRS_BL8 3'h4
`define SBRW_PAIRS_BC4 3'h2
// ==========================================================
// Strobe pattern per beat pair, spacing and watchdog bound
`define SBRW_DQS_PAT 2'h2
`define SBRW_CCD 3
`define SBRW_BUSY_MAX 8'h80
`endif

// ---- hw/sbrw_pkg.sv ----
// Types shared by the DDR burst read/write engine
package sbrw_pkg;
`include "sbrw_params.svh"
	// Mode settings from the system side
	typedef struct packed {
		logic [1:0] bl_code;
		logic [`SBRW_LAT_W-1:0] cl;
		logic [`SBRW_LAT_W-1:0] al;
		logic [`SBRW_LAT_W-1:0] cwl;
	} sbrw_cfg_t;
	// Column command from the controller
	typedef struct packed {
		logic valid;
		logic is_write;
		logic auto_pre;
		logic burst_select_address_bit;
		logic [`SBRW_BANK_W-1:0] bank;
		logic [`SBRW_COL_W-1:0] col;
	} sbrw_cmd_t;
	// Two data beats of one link cycle
	typedef struct packed {
		logic [`SBRW_DQ_W-1:0] rise;
		logic [`SBRW_DQ_W-1:0] fall;
	} sbrw_dq_pair_t;
	// Two mask beats of one link cycle
	typedef struct packed {
		logic [`SBRW_LANES-1:0] rise;
		logic [`SBRW_LANES-1:0] fall;
	} sbrw_dm_pair_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RD = 2'b01,
		ST_WR = 2'b10,
		ST_DONE = 2'b11
	} sbrw_state_t;
endpackage : sbrw_pkg

// ---- hw/sbrw_sync.sv ----
// Three-stage synchroniser with agreement filter
`timescale 1ns/100ps
module sbrw_sync #(
	parameter int W = 1
) (
	// Clock and reset of the receiving domain
	input wire logic clk,
	input wire logic rst,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// ==========================================================
	// Per-bit stages
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			// First stage feeds only the second
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
				end else begin
					s1_q <= d[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
				end
			end
			// Output follows once second and third agree
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					q[i] <= 1'b0;
				end else if (s2_q == s3_q) begin
					q[i] <= s3_q;
				end
			end
		end
	endgenerate
endmodule : sbrw_sync

// ---- hw/sbrw_mem.sv ----
// Cell array with two beat ports and byte-lane write enables
`timescale 1ns/100ps
`include "sbrw_params.svh"
module sbrw_mem #(
	parameter int AW = `SBRW_BANK_W + `SBRW_COL_W,
	parameter int DW = `SBRW_DQ_W,
	parameter int LANES = `SBRW_LANES
) (
	// Clock
	input wire logic clk,
	// Beat ports
	input wire logic we,
	input wire logic [1:0][AW-1:0] addr,
	input wire logic [1:0][DW-1:0] wdata,
	input wire logic [1:0][LANES-1:0] wbe,
	output logic [1:0][DW-1:0] rdata
);
	import sbrw_pkg::*;
	logic [DW-1:0] cells [0:(1<<AW)-1];
	// ==========================================================
	// Lane-masked writes; only the addressed words change
	always_ff @(posedge clk) begin
		if (we) begin
			for (int p = 0; p < 2; p++) begin
				for (int l = 0; l < LANES; l++) begin
					if (wbe[p][l]) begin
						cells[addr[p]][l*8 +: 8] <= wdata[p][l*8 +: 8];
					end
				end
			end
		end
	end
	// Combinational read of both beats
	always_comb begin
		rdata[0] = cells[addr[0]];
		rdata[1] = cells[addr[1]];
	end
endmodule : sbrw_mem

// ---- hw/sbrw_ctrl.sv ----
// DDR device-side burst read/write engine on the link clock
`timescale 1ns/100ps
`include "sbrw_params.svh"
// Contract
// (RQ1) Select bit low: chop four, else eight
// (RQ2) Select bit never forms column address
// (RQ3) Eight beats: fixed code, or on-the-fly high
// (RQ4) Read data starts additive plus cas latency
// (RQ5) Release at latency plus four or two
// (RQ6) Controller spaces read to precharge
// (RQ7) Read-to-precharge at least 4 cycles/7.5ns
// (RQ8) Controller also keeps activate-to-precharge minimum
// (RQ9) Reactivate after precharge and row cycle
// (RQ10) Controller reinitialises after general timing violation
// (RQ11) Setup/hold error corrupts only addressed word
// (RQ12) Strobe errors corrupt only addressed word
// (RQ13) Controller meets timing on every strobe edge
// (RQ14) One mask input per eight data lines
// (RQ15) Mask sampled with its data beat
// (RQ16) Mask ignored during reads
// (RQ17) One beat per strobe edge, both edges
module sbrw_ctrl (
	// System clock domain
	input wire logic clk_sys,
	input wire logic rst,
	input wire sbrw_pkg::sbrw_cfg_t cfg,
	output logic [15:0] viol_count,
	// Link clock and commands
	input wire logic clk_link,
	input wire sbrw_pkg::sbrw_cmd_t cmd,
	// Data, mask and strobe pins
	input wire sbrw_pkg::sbrw_dq_pair_t dq_i,
	output sbrw_pkg::sbrw_dq_pair_t dq_o,
	output logic dq_oe,
	input wire sbrw_pkg::sbrw_dm_pair_t dm_i,
	input wire logic [1:0] dqs_i,
	output logic [1:0] dqs_o,
	output logic dqs_oe
);
	import sbrw_pkg::*;
	localparam int AW = `SBRW_BANK_W + `SBRW_COL_W;
	localparam int LW = `SBRW_LAT_W + 1;

	// ==========================================================
	// Link-side reset
	logic [1:0] rst_link_q;
	logic rst_link;
	// Asserted at once, released on the link clock
	always_ff @(posedge clk_link or posedge rst) begin
		if (rst) begin
			rst_link_q <= 2'h3;
		end else begin
			rst_link_q <= {rst_link_q[0], 1'b0};
		end
	end
	assign rst_link = rst_link_q[1];

	// ==========================================================
	// Mode settings crossing into the link domain
	sbrw_cfg_t cfg_s;
	sbrw_cfg_t cfg_p_q;
	sbrw_cfg_t cfg_l;
	sbrw_sync #(.W($bits(sbrw_cfg_t))) u_cfg_sync (
		.clk(clk_link),
		.rst(rst_link),
		.d(cfg),
		.q(cfg_s)
	);
	// Word taken only after two equal samples
	// Bits that settle one edge apart never form a mixed setting
	always_ff @(posedge clk_link or posedge rst_link) begin
		if (rst_link) begin
			cfg_p_q <= '0;
			cfg_l <= '0;
		end else begin
			cfg_p_q <= cfg_s;
			if (cfg_s == cfg_p_q) begin
				cfg_l <= cfg_s;
			end
		end
	end

	// ==========================================================
	// Command decode
	sbrw_state_t state_q;
	logic [LW-1:0] wait_q;
	logic [2:0] pairs_q;
	logic [1:0] pair_q;
	logic [`SBRW_BANK_W-1:0] bank_q;
	logic [`SBRW_COL_W-1:0] col_q;
	logic accept;
	logic bl8_sel;
	logic [LW-1:0] rl;
	logic [LW-1:0] wl;
	logic [LW-1:0] lat_sel;
	logic beat_now;
	logic last_pair;

	assign accept = cmd.valid && (state_q == ST_IDLE);
	// Burst length from the mode field and the select bit
	assign bl8_sel = (cfg_l.bl_code == `SBRW_BL_FIXED8) ||
		((cfg_l.bl_code == `SBRW_BL_OTF) && cmd.burst_select_address_bit); // RQ3 RQ1
	// Read and write latencies
	assign rl = LW'(cfg_l.al) + LW'(cfg_l.cl); // RQ4
	assign wl = LW'(cfg_l.al) + LW'(cfg_l.cwl);
	assign lat_sel = cmd.is_write ? wl : rl;
	assign beat_now = (wait_q == '0) && ((state_q == ST_RD) || (state_q == ST_WR));
	assign last_pair = (3'({1'b0, pair_q}) + 3'h1) == pairs_q;

	// ==========================================================
	// Burst sequencer
	always_ff @(posedge clk_link or posedge rst_link) begin
		if (rst_link) begin
			state_q <= ST_IDLE;
			wait_q <= '0;
			pairs_q <= '0;
			pair_q <= '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (accept) begin
						state_q <= cmd.is_write ? ST_WR : ST_RD;
						wait_q <= (lat_sel == '0) ? '0 : LW'(lat_sel - LW'(1)); // RQ4
						pairs_q <= bl8_sel ? `SBRW_PAIRS_BL8 : `SBRW_PAIRS_BC4; // RQ1
						pair_q <= '0;
					end
				end
				ST_RD, ST_WR: begin
					// Fixed beat count: strobe faults never stall it
					if (wait_q != '0) begin
						wait_q <= LW'(wait_q - LW'(1));
					end else if (last_pair) begin
						state_q <= ST_DONE; // RQ11 RQ12
					end else begin
						pair_q <= 2'(pair_q + 2'h1);
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Column address held apart from the select bit
	always_ff @(posedge clk_link or posedge rst_link) begin
		if (rst_link) begin
			bank_q <= '0;
			col_q <= '0;
		end else if (accept) begin
			bank_q <= cmd.bank;
			col_q <= cmd.col; // RQ2
		end
	end

	// ==========================================================
	// Beat addresses, sequential wrap inside eight words
	logic [1:0][AW-1:0] mem_addr;
	logic [1:0][`SBRW_DQ_W-1:0] mem_wdata;
	logic [1:0][`SBRW_LANES-1:0] mem_be;
	logic [1:0][`SBRW_DQ_W-1:0] mem_rdata;
	logic mem_we;
	logic [`SBRW_WRAP_W-1:0] lo0;
	logic [`SBRW_WRAP_W-1:0] lo1;

	assign lo0 = `SBRW_WRAP_W'(col_q[`SBRW_WRAP_W-1:0] + {pair_q, 1'b0});
	assign lo1 = `SBRW_WRAP_W'(lo0 + `SBRW_WRAP_W'(1));
	assign mem_addr[0] = {bank_q, col_q[`SBRW_COL_W-1:`SBRW_WRAP_W], lo0};
	assign mem_addr[1] = {bank_q, col_q[`SBRW_COL_W-1:`SBRW_WRAP_W], lo1};
	// Write beats; mask high blocks its lane, same beat as data
	assign mem_we = beat_now && (state_q == ST_WR); // RQ16
	assign mem_wdata[0] = dq_i.rise; // RQ17
	assign mem_wdata[1] = dq_i.fall;
	assign mem_be[0] = ~dm_i.rise; // RQ14 RQ15
	assign mem_be[1] = ~dm_i.fall;

	sbrw_mem u_mem (
		.clk(clk_link),
		.we(mem_we),
		.addr(mem_addr),
		.wdata(mem_wdata),
		.wbe(mem_be),
		.rdata(mem_rdata)
	);

	// ==========================================================
	// Read output drivers
	always_ff @(posedge clk_link or posedge rst_link) begin
		if (rst_link) begin
			dq_o <= '0;
			dq_oe <= 1'b0;
			dqs_o <= '0;
			dqs_oe <= 1'b0;
		end else if (beat_now && (state_q == ST_RD)) begin
			dq_o.rise <= mem_rdata[0]; // RQ17
			dq_o.fall <= mem_rdata[1];
			dq_oe <= 1'b1; // RQ4
			dqs_o <= `SBRW_DQS_PAT;
			dqs_oe <= 1'b1;
		end else if (state_q != ST_RD) begin
			dq_oe <= 1'b0; // RQ5
			dqs_oe <= 1'b0;
			dqs_o <= '0;
		end
	end

	// ==========================================================
	// Write strobe check, reported as a toggle
	logic viol_tgl_q;
	always_ff @(posedge clk_link or posedge rst_link) begin
		if (rst_link) begin
			viol_tgl_q <= 1'b0;
		end else if (mem_we && (dqs_i != `SBRW_DQS_PAT)) begin
			viol_tgl_q <= ~viol_tgl_q; // RQ12
		end
	end

	// ==========================================================
	// System side: violation counter
	logic viol_tgl_s;
	logic viol_seen_q;
	sbrw_sync #(.W(1)) u_viol_sync (
		.clk(clk_sys),
		.rst(rst),
		.d(viol_tgl_q),
		.q(viol_tgl_s)
	);
	// Counts each toggle once
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			viol_seen_q <= 1'b0;
			viol_count <= '0;
		end else begin
			viol_seen_q <= viol_tgl_s;
			if (viol_seen_q != viol_tgl_s) begin
				viol_count <= 16'(viol_count + 16'h0001);
			end
		end
	end

	// ==========================================================
	// Check helpers
	logic [7:0] since_q;
	logic [7:0] busy_q;
	logic [LW-1:0] rl_q;
	logic bl8_q;
	always_ff @(posedge clk_link or posedge rst_link) begin
		if (rst_link) begin
			since_q <= '0;
			busy_q <= '0;
			rl_q <= '0;
			bl8_q <= 1'b0;
		end else begin
			if (accept) begin
				since_q <= 8'h01;
				rl_q <= rl;
				bl8_q <= bl8_sel;
			end else if (since_q != 8'hff) begin
				since_q <= 8'(since_q + 8'h01);
			end
			busy_q <= (state_q == ST_IDLE) ? 8'h00 : 8'(busy_q + 8'h01);
		end
	end

	default clocking cb @(posedge clk_link);
	endclocking
	default disable iff (rst_link);

	chk_rd_latency: assert property ( // RQ4
		$rose(dq_oe) |-> (since_q == 8'(rl_q + LW'(1))))
		else $error("read data did not start at read latency");
	chk_rd_release: assert property ( // RQ5
		$fell(dq_oe) |-> (since_q == 8'(rl_q + LW'(bl8_q ? 5 : 3))))
		else $error("read drivers released at wrong edge");
	chk_bl8_fixed: assert property ( // RQ3
		(accept && cfg_l.bl_code == `SBRW_BL_FIXED8) |=> (pairs_q == `SBRW_PAIRS_BL8))
		else $error("fixed eight code did not give eight beats");
	chk_bc4_select: assert property ( // RQ1
		(accept && cfg_l.bl_code == `SBRW_BL_OTF && !cmd.burst_select_address_bit)
		|=> (pairs_q == `SBRW_PAIRS_BC4))
		else $error("select bit low did not chop the burst");
	chk_cmd_spacing: assert property ( // RQ1
		accept |=> !accept [*3])
		else $error("column commands closer than four cycles");
	chk_col_addr: assert property ( // RQ2
		accept |=> (col_q == $past(cmd.col)) && (bank_q == $past(cmd.bank)))
		else $error("column address not taken from column bits");
	chk_read_mask: assert property ( // RQ16
		dq_oe |-> !mem_we)
		else $error("cells written during a read burst");
	chk_wr_lanes: assert property ( // RQ14
		(mem_we && dm_i.rise == '1 && dm_i.fall == '1) |-> (mem_be == '0))
		else $error("masked lanes were written");
	chk_no_hang: assert property ( // RQ11
		busy_q < `SBRW_BUSY_MAX)
		else $error("burst sequencer hung");
	chk_bl8_select: assert property ( // RQ3
		(accept && cfg_l.bl_code == `SBRW_BL_OTF && cmd.burst_select_address_bit)
		|=> (pairs_q == `SBRW_PAIRS_BL8))
		else $error("select bit high did not give eight beats");
	chk_rd_strobe: assert property ( // RQ17
		dqs_oe |-> (dqs_o == `SBRW_DQS_PAT) && dq_oe)
		else $error("read strobe not toggling with its data");

	cov_rd_bl8: cover property (accept && !cmd.is_write && bl8_sel);
	cov_rd_bc4: cover property (accept && !cmd.is_write && !bl8_sel);
	cov_wr_burst: cover property (mem_we ##1 (state_q == ST_DONE));
	cov_strobe_viol: cover property (mem_we && (dqs_i != `SBRW_DQS_PAT));
endmodule : sbrw_ctrl

// ---- verif/sbrw_host_model.sv ----
// Controller-side model driving link commands and write data
`timescale 1ns/100ps
module sbrw_host_model (
	// Link clock
	input wire logic clk_link,
	// Command and write pins
	output sbrw_pkg::sbrw_cmd_t cmd,
	output sbrw_pkg::sbrw_dq_pair_t dq_i,
	output sbrw_pkg::sbrw_dm_pair_t dm_i,
	output logic [1:0] dqs_i,
	// Read pins
	input wire sbrw_pkg::sbrw_dq_pair_t dq_o,
	input wire logic dq_oe,
	input wire logic [1:0] dqs_o
);
	import sbrw_pkg::*;
	// ==========================================================
	// Idle levels at time zero
	initial begin
		cmd = '0;
		dq_i = '0;
		dm_i = '0;
		dqs_i = 2'h0;
	end
	// Released lines show the inverse of their last value
	task automatic release_lines();
		dq_i = ~dq_i;
		dm_i = ~dm_i;
		dqs_i = ~dqs_i;
	endtask : release_lines
	// One column command, valid for a single link cycle
	task automatic issue(input logic wr, input logic sel, input logic [12:0] a);
		@(negedge clk_link);
		cmd = '{1'b1, wr, 1'b0, sel, a[12:10], a[9:0]};
		@(negedge clk_link);
		cmd.valid = 1'b0;
	endtask : issue
	// Write burst: beats from edge wl on, then a gap
	task automatic wr(input logic sel, input logic [12:0] a, input int n, input int wl,
		input logic [15:0] d [8], input logic [1:0] m [8], input logic [1:0] s);
		issue(1'b1, sel, a);
		repeat (wl - 1) @(negedge clk_link);
		for (int p = 0; p < n; p++) begin
			dq_i = '{d[2*p], d[2*p+1]};
			dm_i = '{m[2*p], m[2*p+1]};
			dqs_i = s;
			@(negedge clk_link);
		end
		release_lines();
		repeat (3) @(negedge clk_link);
	endtask : wr
	// Read burst: latency, pair count, words and release flag
	task automatic rd(input logic sel, input logic [12:0] a, output int lat, output int n,
		output logic [15:0] q [8], output logic rel_ok);
		lat = 0;
		n = 0;
		rel_ok = 1'b1;
		issue(1'b0, sel, a);
		dm_i = '1;
		while (dq_oe !== 1'b1 && lat < 40) begin
			@(negedge clk_link);
			lat++;
		end
		while (dq_oe === 1'b1 && n < 4) begin
			q[2*n] = dq_o.rise;
			q[2*n+1] = dq_o.fall;
			if (dqs_o !== 2'h2) rel_ok = 1'b0;
			n++;
			@(negedge clk_link);
		end
		if (dqs_o !== 2'h0 || dq_oe !== 1'b0) rel_ok = 1'b0;
		repeat (2) @(negedge clk_link);
	endtask : rd
endmodule : sbrw_host_model

// ---- verif/tb.sv ----
// Testbench of the burst read/write engine
`timescale 1ns/100ps
module tb;
	import sbrw_pkg::*;
	// ==========================================================
	// Clocks, reset, pins and bookkeeping
	logic clk_sys = 1'b0;
	logic clk_link = 1'b0;
	logic rst = 1'b1;
	sbrw_cfg_t cfg = '{2'h1, 5'h05, 5'h00, 5'h05};
	logic [15:0] viol_count;
	sbrw_cmd_t cmd;
	sbrw_dq_pair_t dq_i, dq_o;
	sbrw_dm_pair_t dm_i;
	logic [1:0] dqs_i, dqs_o;
	logic dq_oe, dqs_oe;
	int bad_count = 0;
	int n_checks = 0;
	int pat = 1;
	logic [15:0] mem [logic [12:0]];
	always #2 clk_sys = ~clk_sys;
	always #7.5 clk_link = ~clk_link;
	sbrw_ctrl dut (.clk_sys, .rst, .cfg, .viol_count, .clk_link, .cmd, .dq_i, .dq_o,
		.dq_oe, .dm_i, .dqs_i, .dqs_o, .dqs_oe);
	sbrw_host_model host (.clk_link, .cmd, .dq_i, .dm_i, .dqs_i, .dq_o, .dq_oe, .dqs_o);
	// ==========================================================
	// Helpers
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : check
	function automatic logic [12:0] wa(input logic [12:0] a, input int k);
		return {a[12:3], 3'(a[2:0] + k)};
	endfunction : wa
	// Write with odd beats masked by m, expectations kept per word
	task automatic wr_exp(input logic sel, input logic [12:0] a, input int n,
		input logic [1:0] m, input logic [1:0] s);
		logic [15:0] d [8];
		logic [1:0] mk [8];
		int wl;
		wl = cfg.al + cfg.cwl;
		if (wl == 0) wl = 1;
		pat++;
		for (int k = 0; k < 8; k++) begin
			d[k] = 16'(pat * 16'h1357 + k * 16'h0111);
			mk[k] = k[0] ? m : 2'h0;
			for (int l = 0; l < 2 && k < 2 * n; l++) begin
				if (!mk[k][l]) mem[wa(a, k)][8*l+:8] = d[k][8*l+:8];
			end
		end
		host.wr(sel, a, n, wl, d, mk, s);
	endtask : wr_exp
	task automatic rd_exp(input logic sel, input logic [12:0] a, input int n);
		int lat, got_n;
		logic [15:0] q [8];
		logic rel_ok;
		host.rd(sel, a, lat, got_n, q, rel_ok);
		check("read latency", cfg.al + cfg.cl, lat);
		check("pair count", n, got_n);
		check("strobe release", 1, rel_ok);
		for (int k = 0; k < 2 * n; k++) check("read word", mem[wa(a, k)], q[k]);
	endtask : rd_exp
	task automatic set_cfg(input logic [1:0] bl, input logic [4:0] al);
		@(negedge clk_sys);
		cfg.bl_code = bl;
		cfg.al = al;
		repeat (10) @(negedge clk_link);
	endtask : set_cfg
	// Strobe enable follows data enable
	always @(negedge clk_link) if (!rst && dqs_oe !== dq_oe) check("strobe oe", dq_oe, dqs_oe);
	// ==========================================================
	// Scenarios
	task automatic t_bursts();
		wr_exp(1'b1, 13'h0123, 4, 2'h0, 2'h2);
		wr_exp(1'b1, 13'h0123, 4, 2'h2, 2'h2);
		rd_exp(1'b1, 13'h0123, 4);
		wr_exp(1'b1, 13'h10A6, 4, 2'h0, 2'h2);
		wr_exp(1'b0, 13'h10A6, 2, 2'h1, 2'h2);
		rd_exp(1'b0, 13'h10A6, 2);
		rd_exp(1'b1, 13'h10A6, 4);
		$display("test bursts done");
	endtask : t_bursts
	task automatic t_fixed_latency();
		set_cfg(2'h0, 5'h04);
		wr_exp(1'b0, 13'h0123, 4, 2'h1, 2'h2);
		rd_exp(1'b0, 13'h0123, 4);
		set_cfg(2'h2, 5'h00);
		rd_exp(1'b1, 13'h0123, 2);
		set_cfg(2'h1, 5'h00);
		$display("test fixed latency done");
	endtask : t_fixed_latency
	task automatic t_strobe_fault();
		logic [15:0] cnt0;
		cnt0 = viol_count;
		wr_exp(1'b1, 13'h0200, 4, 2'h0, 2'h1);
		repeat (20) @(negedge clk_sys);
		check("violations", 16'(cnt0 + 16'h0004), viol_count);
		rd_exp(1'b1, 13'h0123, 4);
		$display("test strobe fault done");
	endtask : t_strobe_fault
	// Full reinitialisation after a timing fault; cells keep their words
	task automatic t_reinit();
		@(negedge clk_sys);
		rst = 1'b1;
		repeat (12) @(negedge clk_sys);
		check("drivers in reset", 0, {dq_oe, dqs_oe, dqs_o});
		check("count in reset", 0, viol_count);
		rst = 1'b0;
		repeat (10) @(negedge clk_link);
		rd_exp(1'b1, 13'h0123, 4);
		$display("test reinit done");
	endtask : t_reinit
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	initial begin
		repeat (12) @(negedge clk_sys);
		rst = 1'b0;
		repeat (10) @(negedge clk_link);
		t_bursts();
		t_fixed_latency();
		t_strobe_fault();
		t_reinit();
		end_of_test();
	end
	// Watchdog well beyond the expected run
	initial begin
		#100000;
		bad_count++;
		end_of_test();
	end
endmodule : tb
